// file: src/strip_midi_defs.vh
`ifndef STRIP_MIDI_DEFS_VH
`define STRIP_MIDI_DEFS_VH

`define NUM_STRIPS 32
`define STRIP_IDX_W 5
`define NOTE_ON 4'h9
`define NOTE_OFF 4'h8
`define CTRL_CHANGE 4'hb
`define SELECT_NOTE_BASE 7'h20
`define LISTEN_NOTE_BASE 7'h40
`define NOTE_LIMIT 7'h60
`define MAIN_CH_RESET 4'h0
`define CH_CODE_TO_STRIP 4'h2
`define STRIP_CH_RESET 4'h2
`define VEL_ON 7'h7f
`define VEL_OFF 7'h00
`define SYSEX_START 8'hf0
`define SYSEX_END 8'hf7
`define SYSEX_ID 8'h7f
`define ALL_DEV 8'h7f
`define MMC_SUB 8'h06
`define MMC_LEN 3'h6
`define CMD_BANK 4'hb

`endif

// file: src/fader_store.v
`timescale 1ns/1ps

// small register file holding the last sent 7-bit value for each fader
module fader_store (
	input wire sys_clk_in,
	input wire reset_n_in,
	input wire wr_en_in,
	input wire [4:0] wr_addr_in,
	input wire [6:0] wr_data_in,
	input wire [4:0] rd_addr_in,
	output reg [6:0] rd_data_out
);

	reg [6:0] mem_q [0:31];
	integer i;

	always @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			for (i = 0; i < 32; i = i + 1)
				mem_q[i] <= 7'h00;
			rd_data_out <= 7'h00;
		end else begin
			if (wr_en_in)
				mem_q[wr_addr_in] <= wr_data_in;
			rd_data_out <= mem_q[rd_addr_in];
		end
	end

endmodule // fader_store

// file: src/midi_fader_strip_codec.v
`timescale 1ns/1ps
`include "strip_midi_defs.vh"

module midi_fader_strip_codec (
	input wire sys_clk_in,
	input wire reset_n_in,
	input wire key_valid_in,
	input wire [1:0] key_kind_in,
	input wire [4:0] key_strip_in,
	input wire [4:0] fader_strip_in,
	input wire [9:0] fader_pos_in,
	input wire [3:0] chan_pending_in,
	input wire chan_apply_in,
	input wire chan_cancel_in,
	input wire mmc_valid_in,
	input wire [7:0] mmc_cmd_in,
	input wire assign_valid_in,
	input wire [1:0] assign_mode_in,
	input wire [7:0] assign_data_in,
	input wire [6:0] assign_value_in,
	input wire [7:0] rx_byte_in,
	input wire rx_valid_in,
	output wire tx_ready_out,
	output reg [7:0] tx_byte_out,
	output reg tx_valid_out,
	input wire tx_ready_in,
	output reg [3:0] strip_chan_out,
	output reg strip_key_valid_out,
	output reg [1:0] strip_key_kind_out,
	output reg [4:0] strip_key_idx_out,
	output reg strip_key_on_out,
	output reg strip_fader_valid_out,
	output reg [4:0] strip_fader_idx_out,
	output reg [6:0] strip_fader_val_out
);

	// key_kind: 0 mute, 1 select, 2 listen. assign_mode: 0 cc, 1 mmc, 2 bank up, 3 bank down
	localparam S_IDLE = 3'h0;
	localparam S_FREAD = 3'h1;
	localparam S_FCMP = 3'h2;
	localparam S_SEND = 3'h3;
	localparam S_OFF = 3'h4;

	reg [2:0] state_q;
	reg [3:0] main_chan_q;
	reg [7:0] msg_q [0:5];
	reg [2:0] len_q;
	reg [2:0] idx_q;
	reg off_pend_q;
	reg [6:0] off_note_q;
	reg [4:0] fidx_q;
	reg [6:0] fval_q;
	wire [6:0] fstored;
	wire [6:0] fquant;
	wire fwr;
	integer k;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function [6:0] key_note;
		input [1:0] kind;
		input [4:0] strip;
		begin
			case (kind)
				2'h1: key_note = `SELECT_NOTE_BASE + {2'h0, strip};
				2'h2: key_note = `LISTEN_NOTE_BASE + {2'h0, strip};
				default: key_note = {2'h0, strip};
			endcase
		end
	endfunction

	function [3:0] strip_chan;
		input [3:0] main;
		begin
			// main code 0 is channel 1, strips sit one channel above it
			strip_chan = main + `CH_CODE_TO_STRIP;
		end
	endfunction

	// ------------------------------------------------------------
	// channel setting
	// ------------------------------------------------------------
	always @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			main_chan_q <= `MAIN_CH_RESET;
			strip_chan_out <= `STRIP_CH_RESET;
		end else begin
			if (chan_apply_in && !chan_cancel_in) begin
				main_chan_q <= chan_pending_in;
				strip_chan_out <= strip_chan(chan_pending_in);
			end
		end
	end

	// ------------------------------------------------------------
	// transmit sequencer
	// ------------------------------------------------------------
	assign fquant = fader_pos_in[9:3];
	assign fwr = (state_q == S_FCMP) && (fstored != fval_q);
	assign tx_ready_out = (state_q == S_IDLE) && !off_pend_q;

	fader_store u_store (
		.sys_clk_in(sys_clk_in),
		.reset_n_in(reset_n_in),
		.wr_en_in(fwr),
		.wr_addr_in(fidx_q),
		.wr_data_in(fval_q),
		.rd_addr_in(fidx_q),
		.rd_data_out(fstored)
	);

	always @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_q <= S_IDLE;
			len_q <= 3'h0;
			idx_q <= 3'h0;
			off_pend_q <= 1'b0;
			off_note_q <= 7'h00;
			fidx_q <= 5'h00;
			fval_q <= 7'h00;
			tx_byte_out <= 8'h00;
			tx_valid_out <= 1'b0;
			for (k = 0; k < 6; k = k + 1)
				msg_q[k] <= 8'h00;
		end else begin
			case (state_q)
				S_IDLE: begin
					tx_valid_out <= 1'b0;
					idx_q <= 3'h0;
					if (off_pend_q) begin
						off_pend_q <= 1'b0;
						msg_q[0] <= {`NOTE_OFF, strip_chan_out - 4'h1};
						msg_q[1] <= {1'b0, off_note_q};
						msg_q[2] <= {1'b0, `VEL_OFF};
						len_q <= 3'h3;
						state_q <= S_SEND;
					end else if (key_valid_in && key_kind_in != 2'h3) begin
						off_pend_q <= 1'b1;
						off_note_q <= key_note(key_kind_in, key_strip_in);
						msg_q[0] <= {`NOTE_ON, strip_chan_out - 4'h1};
						msg_q[1] <= {1'b0, key_note(key_kind_in, key_strip_in)};
						msg_q[2] <= {1'b0, `VEL_ON};
						len_q <= 3'h3;
						state_q <= S_SEND;
					end else if (mmc_valid_in || (assign_valid_in && assign_mode_in != 2'h0)) begin
						msg_q[0] <= `SYSEX_START;
						msg_q[1] <= `SYSEX_ID;
						msg_q[2] <= `ALL_DEV;
						msg_q[3] <= `MMC_SUB;
						if (mmc_valid_in)
							msg_q[4] <= mmc_cmd_in;
						else if (assign_mode_in == 2'h1)
							msg_q[4] <= assign_data_in;
						else
							msg_q[4] <= {`CMD_BANK, 3'h0, assign_mode_in[0]};
						msg_q[5] <= `SYSEX_END;
						len_q <= `MMC_LEN;
						state_q <= S_SEND;
					end else if (assign_valid_in) begin
						msg_q[0] <= {`CTRL_CHANGE, main_chan_q};
						msg_q[1] <= {1'b0, assign_data_in[6:0]};
						msg_q[2] <= {1'b0, assign_value_in};
						len_q <= 3'h3;
						state_q <= S_SEND;
					end else begin
						fidx_q <= fidx_q + 5'h01;
						fval_q <= fquant;
						state_q <= S_FREAD;
					end
				end
				S_FREAD: state_q <= S_FCMP;
				S_FCMP: begin
					if (fstored != fval_q) begin
						msg_q[0] <= {`CTRL_CHANGE, strip_chan_out - 4'h1};
						msg_q[1] <= {3'h0, fidx_q};
						msg_q[2] <= {1'b0, fval_q};
						len_q <= 3'h3;
						state_q <= S_SEND;
					end else begin
						state_q <= S_IDLE;
					end
				end
				S_SEND: begin
					if (!tx_valid_out || tx_ready_in) begin
						if (idx_q == len_q) begin
							tx_valid_out <= 1'b0;
							state_q <= S_IDLE;
						end else begin
							tx_byte_out <= msg_q[idx_q];
							tx_valid_out <= 1'b1;
							idx_q <= idx_q + 3'h1;
						end
					end
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// receive parser
	// ------------------------------------------------------------
	reg [7:0] rx_stat_q;
	reg [6:0] rx_d1_q;
	reg rx_have1_q;
	wire rx_ours = rx_stat_q[3:0] == (strip_chan_out - 4'h1);
	wire [6:0] rnote = rx_d1_q;

	always @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rx_stat_q <= 8'h00;
			rx_d1_q <= 7'h00;
			rx_have1_q <= 1'b0;
			strip_key_valid_out <= 1'b0;
			strip_key_kind_out <= 2'h0;
			strip_key_idx_out <= 5'h00;
			strip_key_on_out <= 1'b0;
			strip_fader_valid_out <= 1'b0;
			strip_fader_idx_out <= 5'h00;
			strip_fader_val_out <= 7'h00;
		end else begin
			strip_key_valid_out <= 1'b0;
			strip_fader_valid_out <= 1'b0;
			if (rx_valid_in) begin
				if (rx_byte_in[7]) begin
					rx_stat_q <= rx_byte_in;
					rx_have1_q <= 1'b0;
				end else if (!rx_have1_q) begin
					rx_d1_q <= rx_byte_in[6:0];
					rx_have1_q <= 1'b1;
				end else begin
					rx_have1_q <= 1'b0;
					if (rx_ours && rx_stat_q[7:4] == `CTRL_CHANGE && rnote < 7'h20) begin
						strip_fader_valid_out <= 1'b1;
						strip_fader_idx_out <= rnote[4:0];
						strip_fader_val_out <= rx_byte_in[6:0];
					end else if (rx_ours && rnote < `NOTE_LIMIT &&
						(rx_stat_q[7:4] == `NOTE_ON || rx_stat_q[7:4] == `NOTE_OFF)) begin
						strip_key_valid_out <= 1'b1;
						strip_key_kind_out <= rnote[6:5];
						strip_key_idx_out <= rnote[4:0];
						strip_key_on_out <= (rx_stat_q[7:4] == `NOTE_ON) && (rx_byte_in != 8'h00);
					end
				end
			end
		end
	end

endmodule // midi_fader_strip_codec

// file: verification/midi_sink.sv
`timescale 1ns/1ps
// ----
// byte sink standing in for the host software
// ----
module midi_sink (
	input wire sys_clk_in,
	input wire reset_n_in,
	input wire slow_in,
	output reg ready_out
);
always @(posedge sys_clk_in or negedge reset_n_in) begin
	if (!reset_n_in)
		ready_out <= 1'h0;
	else
		ready_out <= slow_in ? ~ready_out : 1'h1;
end
endmodule // midi_sink

// file: verification/codec_chk_asserts.sv
`timescale 1ns/1ps
// ----
// port checks
// ----
module codec_chk (
	input wire sys_clk_in,
	input wire reset_n_in,
	input wire key_valid_in,
	input wire [1:0] key_kind_in,
	input wire [3:0] chan_pending_in,
	input wire chan_apply_in,
	input wire chan_cancel_in,
	input wire mmc_valid_in,
	input wire tx_ready_out,
	input wire [7:0] tx_byte_out,
	input wire tx_valid_out,
	input wire tx_ready_in,
	input wire [3:0] strip_chan_out,
	input wire strip_key_valid_out,
	input wire [1:0] strip_key_kind_out,
	input wire strip_fader_valid_out
);
default clocking @(posedge sys_clk_in); endclocking
default disable iff (!reset_n_in);
hold_byte_a: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_byte_out))
	else $error("byte lost");
busy_tx_a: assert property (tx_valid_out |-> !tx_ready_out)
	else $error("ready while sending");
note_on_a: assert property (key_valid_in && tx_ready_out && key_kind_in != 2'h3
	|-> ##2 tx_valid_out && tx_byte_out == {4'h9, strip_chan_out - 4'h1})
	else $error("bad note-on");
mmc_start_a: assert property (mmc_valid_in && tx_ready_out && !key_valid_in
	|-> ##2 tx_valid_out && tx_byte_out == 8'hf0)
	else $error("bad mmc start");
apply_chan_a: assert property (chan_apply_in && !chan_cancel_in
	|=> strip_chan_out == $past(chan_pending_in) + 4'h2)
	else $error("bad apply");
cancel_keep_a: assert property (chan_cancel_in |=> $stable(strip_chan_out))
	else $error("cancel changed channel");
rx_kind_a: assert property (strip_key_valid_out |-> strip_key_kind_out != 2'h3)
	else $error("bad key kind");
rx_pulse_a: assert property (strip_key_valid_out || strip_fader_valid_out
	|=> !strip_key_valid_out && !strip_fader_valid_out)
	else $error("rx pulse too long");
key_cv: cover property (key_valid_in && tx_ready_out);
mmc_cv: cover property (mmc_valid_in && tx_ready_out);
apply_cv: cover property (chan_apply_in && chan_cancel_in);
endmodule // codec_chk
bind midi_fader_strip_codec codec_chk i_codec_chk (.*);

// file: verification/tb_top.sv
`timescale 1ns/1ps
// ----
// bench
// ----
module tb_top;
reg sys_clk_in = '0, reset_n_in = '0, key_valid_in = '0, chan_apply_in = '0, chan_cancel_in = '0;
reg mmc_valid_in = '0, assign_valid_in = '0, rx_valid_in = '0, slow = '0;
reg [1:0] key_kind_in = '0, assign_mode_in = '0;
reg [4:0] key_strip_in = '0, fader_strip_in = '0;
reg [9:0] fader_pos_in = '0;
reg [3:0] chan_pending_in = '0, sc = 4'h1;
reg [7:0] mmc_cmd_in = '0, assign_data_in = '0, rx_byte_in = '0, b, rk;
reg [6:0] assign_value_in = '0;
reg [11:0] rf;
wire tx_ready_out, tx_valid_out, tx_ready_in, strip_key_valid_out, strip_key_on_out;
wire strip_fader_valid_out;
wire [7:0] tx_byte_out;
wire [3:0] strip_chan_out;
wire [1:0] strip_key_kind_out;
wire [4:0] strip_key_idx_out, strip_fader_idx_out;
wire [6:0] strip_fader_val_out;
integer fails = 0, n_checks = 0, cyc = 0, nk = 0, i, k, s, u;
reg [7:0] q[$];
midi_fader_strip_codec i_midi_fader_strip_codec (.*);
midi_sink i_midi_sink (.sys_clk_in, .reset_n_in, .slow_in(slow), .ready_out(tx_ready_in));
always #50 sys_clk_in = ~sys_clk_in;
always @(posedge sys_clk_in) begin
	cyc <= cyc + 1;
	if (tx_valid_out && tx_ready_in)
		q.push_back(tx_byte_out);
	if (strip_key_valid_out)
		rk <= {strip_key_kind_out, strip_key_idx_out, strip_key_on_out};
	if (strip_key_valid_out)
		nk <= nk + 1;
	if (strip_fader_valid_out)
		rf <= {strip_fader_idx_out, strip_fader_val_out};
	if (cyc == 30000) begin
		fails = fails + 1;
		summarize;
	end
end
task summarize;
	if (fails == 0 && n_checks > 0)
		$display("All tests passed");
	else
		$display("Some tests failed");
	$finish;
endtask
task chk(input [15:0] seen, input [15:0] exp);
	n_checks = n_checks + 1;
	if (seen !== exp) begin
		fails = fails + 1;
		$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
	end
endtask
task tick(input integer n);
	repeat (n) @(posedge sys_clk_in);
	#1;
endtask
task get;
	for (u = 0; u < 300 && q.size() == 0; u = u + 1)
		tick(1);
	b = q.size() ? q.pop_front() : 8'hxx;
endtask
task pull(input [7:0] e);
	get;
	chk(b, e);
endtask
task press(input [1:0] kd, input [4:0] st);
	for (u = 0; u < 300 && !tx_ready_out; u = u + 1)
		tick(1);
	key_kind_in = kd;
	key_strip_in = st;
	key_valid_in = 1'h1;
	tick(1);
	key_valid_in = 1'h0;
endtask
task note(input [7:0] n);
	pull({4'h9, sc});
	pull(n);
	pull(8'h7f);
	pull({4'h8, sc});
	pull(n);
	pull(8'h00);
endtask
task frame(input [7:0] c);
	pull(8'hf0);
	pull(8'h7f);
	pull(8'h7f);
	pull(8'h06);
	pull(c);
	pull(8'hf7);
endtask
task setch(input [3:0] p, input c);
	chan_pending_in = p;
	chan_apply_in = 1'h1;
	chan_cancel_in = c;
	tick(1);
	chan_apply_in = 1'h0;
	chan_cancel_in = 1'h0;
	tick(1);
endtask
task rxb(input [7:0] v);
	rx_byte_in = v;
	rx_valid_in = 1'h1;
	tick(1);
	rx_valid_in = 1'h0;
	tick(1);
endtask
task rx3(input [7:0] a, input [7:0] d, input [7:0] c);
	rxb(a);
	rxb(d);
	rxb(c);
endtask
task keys;
	for (k = 0; k < 4; k = k + 1) begin
		for (i = 0; i < 32; i = i + 31) begin
			slow = i[0];
			press(k[1:0], i[4:0]);
			if (k < 3)
				note(8'(k * 32 + i));
		end
	end
	tick(20);
	chk(q.size(), 0);
endtask
task chan;
	setch(4'hf, 1'h0);
	chk(strip_chan_out, 4'h1);
	sc = 4'h0;
	press(2'h0, 5'h00);
	note(8'h00);
	setch(4'h5, 1'h1);
	chk(strip_chan_out, 4'h1);
	setch(4'h0, 1'h0);
	chk(strip_chan_out, 4'h2);
	sc = 4'h1;
endtask
task mmc;
	for (k = 0; k < 10; k = k + 1) begin
		press(2'h3, 5'h00);
		for (u = 0; u < 300 && !tx_ready_out; u = u + 1)
			tick(1);
		mmc_cmd_in = 8'(k + 1);
		assign_mode_in = 2'(k - 6);
		assign_data_in = 8'h09;
		assign_value_in = 7'h55;
		mmc_valid_in = k < 6;
		assign_valid_in = k >= 6;
		tick(1);
		mmc_valid_in = 1'h0;
		assign_valid_in = 1'h0;
		if (k == 6) begin
			pull(8'hb0);
			pull(8'h09);
			pull(8'h55);
		end else
			frame(k < 6 ? 8'(k + 1) : k == 7 ? 8'h09 : 8'(k + 168));
	end
endtask
task rx;
	rx3(8'h91, 8'h05, 8'h7f);
	chk(rk, {2'h0, 5'h05, 1'h1});
	rx3(8'h91, 8'h45, 8'h00);
	chk(rk, {2'h2, 5'h05, 1'h0});
	rx3(8'h91, 8'h3f, 8'h7f);
	chk(rk, {2'h1, 5'h1f, 1'h1});
	k = nk;
	rx3(8'h92, 8'h05, 8'h7f);
	chk(nk - k, 0);
endtask
task fader;
	fader_pos_in = 10'h3f8;
	s = 0;
	for (k = 0; k < 32; k = k + 1) begin
		pull(8'hb1);
		get;
		s = s + b;
		pull(8'h7f);
	end
	chk(s, 16'h1f0);
	fader_pos_in = 10'h3ff;
	tick(200);
	chk(q.size(), 0);
	rx3(8'hb1, 8'h03, 8'h7f);
	chk(rf, {5'h03, 7'h7f});
endtask
initial begin
	tick(2);
	reset_n_in = 1'h1;
	tick(2);
	chk(strip_chan_out, 4'h2);
	keys;
	chan;
	mmc;
	rx;
	fader;
	summarize;
end
endmodule // tb_top
